// *** logic/sbcreg_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbcreg_mem (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Write port
    input wire logic wr_en,
    input wire logic [4:0] wr_idx,
    input wire logic [7:0] wr_data,
    // Registered read port
    input wire logic [4:0] rd_idx,
    output logic [7:0] rd_data
);
    logic [7:0] mem [sbcreg_pkg::NUM_CTRL];

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < sbcreg_pkg::NUM_CTRL; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (wr_en && (int'(wr_idx) < sbcreg_pkg::NUM_CTRL)) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rd_data <= 8'h00;
        end else if (int'(rd_idx) < sbcreg_pkg::NUM_CTRL) begin
            rd_data <= mem[rd_idx];
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// *** logic/sbcreg_pkg.sv ***
`default_nettype none
package sbcreg_pkg;
    // ========================================================================
    // Register address map
    localparam int NUM_CTRL = 19;
    localparam int NUM_STAT = 5;
    localparam logic [4:0] SLOT_NONE = 5'h1f;
    localparam logic [6:0] CTRL_SPACE_END = 7'h3f;
    localparam logic [6:0] STAT_SPACE_END = 7'h7e;
    localparam logic [6:0] CTRL_ADDR [NUM_CTRL] = '{
        7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h07, 7'h08, 7'h0b, 7'h0c, 7'h0e,
        7'h0f, 7'h17, 7'h18, 7'h1c, 7'h1d, 7'h1a, 7'h1b, 7'h20, 7'h21};
    localparam logic [7:0] CTRL_MASK [NUM_CTRL] = '{
        8'hdf, 8'h65, 8'hf7, 8'h07, 8'h44, 8'ha1, 8'hc3, 8'h10, 8'h7f, 8'hfe,
        8'hfd, 8'h07, 8'hff, 8'h03, 8'h07, 8'hff, 8'hff, 8'hf1, 8'hff};
    localparam logic [6:0] STAT_ADDR [NUM_STAT] = '{7'h41, 7'h43, 7'h48, 7'h4a, 7'h7e};
    localparam logic [NUM_STAT-1:0] STAT_CLEARABLE = 5'h03;
    // Slots with logic of their own
    localparam logic [4:0] SLOT_MODE = 5'h00;
    localparam logic [4:0] SLOT_HW0 = 5'h01;
    localparam logic [4:0] SLOT_WD = 5'h02;
    localparam logic [4:0] SLOT_CAN = 5'h03;
    localparam logic [4:0] STAT_SUP = 5'h00;
    localparam logic [4:0] STAT_DEV = 5'h01;
    localparam logic [4:0] STAT_WKLVL = 5'h02;
    localparam logic [4:0] STAT_SWK = 5'h03;
    localparam logic [4:0] STAT_IDENT = 5'h04;
    // ========================================================================
    // Field layout
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int REGSW_MSB = 4;
    localparam int REGSW_LSB = 3;
    localparam int MLOW_MSB = 2;
    localparam int CAN_MSB = 2;
    localparam int FO_BIT = 5;
    localparam int REG_FAIL_BIT = 3;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_RESET = 2'h3;
    localparam logic [2:0] CAN_OFF = 3'h0;
    localparam logic [2:0] CAN_WAKE = 3'h1;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_BITS = 5'h08;
    // ========================================================================
    // Types
    typedef enum logic [4:0] {
        M_INIT = 5'h01, M_NORMAL = 5'h02, M_STOP = 5'h04, M_SLEEP = 5'h08,
        M_RESTART = 5'h10
    } sbcreg_mode_t;
    typedef struct packed {
        logic [7:0] data;
        logic access;
        logic [6:0] addr;
    } sbcreg_frame_t;
endpackage
`default_nettype wire

// *** logic/sbcreg_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Addresses 0x00 to 0x1E are read/write general control registers.
// - Access bit 1 writes a control register, 0 only reads it.
// - Addresses 0x20 to 0x3F are selective wake control registers.
// - Written value shows only in the answer of a later command.
// - Addresses 0x40 to 0x7E are status registers, read or read-and-clear.
// - Access bit 1 on a status register returns it, then clears it.
// - Live level, identity and selective wake status ignore clear requests.
// - Mode field always reports the mode actually entered.
// - Entering stop or sleep keeps diagnosis flags unchanged.
// - A triggered fail output stays on through low power and restart.
// - Entering stop leaves the CAN control field untouched.
// - Entering sleep rewrites CAN field unless off or wake capable.
// - Regulator stays on in low power, configurable only in normal mode.
// - Regulator failure in low power switches it off, no wake event.
// - Entering restart clears the regulator switch bits.
// - In restart CAN becomes off or wake capable from prior setting.
// - Frame: address bits 6..0, access bit 7, data bits 15..8.
// - Written configuration takes effect when chip select returns high.
// - Frames touching restart mode are ignored entirely.
// - Missing address goes to next existing one; beyond space reads 0x00.
module sbcreg_top #(
    parameter logic [7:0] FAMILY_ID = 8'h5a // Arbitrary identity value
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Serial port pins
    input wire logic spi_sclk,
    input wire logic chip_select_low,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Device core events
    input wire logic wake_event,
    input wire logic restart_event,
    input wire logic restart_done,
    input wire logic fail_trigger,
    input wire logic regulator_fail,
    input wire logic [7:0] supply_event,
    input wire logic [7:0] device_event,
    input wire logic [7:0] selective_wake_state,
    input wire logic [1:0] wake_pin_level,
    // Controls to the device core
    output sbcreg_pkg::sbcreg_mode_t sbc_mode,
    output logic [1:0] secondary_regulator_switch,
    output logic [2:0] can_mode,
    output logic fail_output,
    output logic watchdog_kick
);
    // ========================================================================
    // Functions
    function automatic logic [4:0] ctrl_slot(input logic [6:0] a);
        logic [4:0] s;
        logic [6:0] best;
        s = sbcreg_pkg::SLOT_NONE;
        best = sbcreg_pkg::CTRL_SPACE_END;
        // Table is not sorted, so keep the lowest address at or above a
        for (int i = 0; i < sbcreg_pkg::NUM_CTRL; i++) begin
            if (a <= sbcreg_pkg::CTRL_SPACE_END && sbcreg_pkg::CTRL_ADDR[i] >= a
                    && sbcreg_pkg::CTRL_ADDR[i] <= best) begin
                s = 5'(i);
                best = sbcreg_pkg::CTRL_ADDR[i];
            end
        end
        return s;
    endfunction

    function automatic logic [4:0] stat_slot(input logic [6:0] a);
        logic [4:0] s;
        s = sbcreg_pkg::SLOT_NONE;
        for (int i = sbcreg_pkg::NUM_STAT - 1; i >= 0; i--) begin
            if (a > sbcreg_pkg::CTRL_SPACE_END && a <= sbcreg_pkg::STAT_SPACE_END
                    && sbcreg_pkg::STAT_ADDR[i] >= a) begin
                s = 5'(i);
            end
        end
        return s;
    endfunction

    function automatic logic [1:0] field_of(input sbcreg_pkg::sbcreg_mode_t m);
        case (m)
            sbcreg_pkg::M_SLEEP: field_of = sbcreg_pkg::MODE_SLEEP;
            sbcreg_pkg::M_STOP: field_of = sbcreg_pkg::MODE_STOP;
            sbcreg_pkg::M_RESTART: field_of = sbcreg_pkg::MODE_RESET;
            default: field_of = sbcreg_pkg::MODE_NORMAL;
        endcase
    endfunction

    function automatic logic can_active(input logic [2:0] c);
        can_active = (c != sbcreg_pkg::CAN_OFF) && (c != sbcreg_pkg::CAN_WAKE);
    endfunction

    // ========================================================================
    // Pin synchronisers and edge detection
    logic sclk_m, sclk_s, sclk_d, csn_m, csn_s, csn_d, mosi_m, mosi_s;
    logic [1:0] wk_m, wk_s;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            csn_m <= 1'b1;
            csn_s <= 1'b1;
            csn_d <= 1'b1;
            mosi_m <= 1'b0;
            mosi_s <= 1'b0;
            wk_m <= 2'h0;
            wk_s <= 2'h0;
        end else begin
            sclk_m <= spi_sclk;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            csn_m <= chip_select_low;
            csn_s <= csn_m;
            csn_d <= csn_s;
            mosi_m <= spi_mosi;
            mosi_s <= mosi_m;
            wk_m <= wake_pin_level;
            wk_s <= wk_m;
        end
    end
    logic sclk_rise, sclk_fall, csn_fall, csn_rise;
    assign sclk_rise = !csn_s && sclk_s && !sclk_d;
    assign sclk_fall = !csn_s && !sclk_s && sclk_d;
    assign csn_fall = !csn_s && csn_d;
    assign csn_rise = csn_s && !csn_d;

    // ========================================================================
    // Frame reception
    logic [15:0] rx;
    logic [4:0] bit_cnt;
    logic [3:0] fall_cnt;
    logic frame_bad;
    sbcreg_pkg::sbcreg_frame_t frame;
    sbcreg_pkg::sbcreg_mode_t mode_state, next_mode;
    assign frame = rx;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rx <= 16'h0000;
            bit_cnt <= 5'h00;
            fall_cnt <= 4'h0;
        end else if (csn_fall) begin
            bit_cnt <= 5'h00;
            fall_cnt <= 4'h0;
        end else begin
            if (sclk_rise) begin
                rx <= {mosi_s, rx[15:1]};
                if (bit_cnt != 5'h1f) begin
                    bit_cnt <= 5'(bit_cnt + 5'h01);
                end
            end
            if (sclk_fall) begin
                fall_cnt <= 4'(fall_cnt + 4'h1);
            end
        end
    end
    // Restart at any time of the frame poisons it
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            frame_bad <= 1'b0;
        end else if (csn_fall) begin
            frame_bad <= (mode_state == sbcreg_pkg::M_RESTART);
        end else if (!csn_s && mode_state == sbcreg_pkg::M_RESTART) begin
            frame_bad <= 1'b1;
        end
    end

    // ========================================================================
    // Address lookup and answer
    logic lk_go, lk_go_d, resp_go, lk_ctrl, lk_stat;
    logic [4:0] lk_slot;
    logic [7:0] mem_rd, resp_byte, summary, resp_mux;
    logic [15:0] resp_word;
    logic [1:0] mode_field, reg_sw;
    logic [2:0] mode_low, can_reg;
    logic fail_latched;
    logic [7:0] sup_stat, dev_stat;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lk_go <= 1'b0;
            lk_go_d <= 1'b0;
            resp_go <= 1'b0;
            lk_ctrl <= 1'b0;
            lk_stat <= 1'b0;
            lk_slot <= sbcreg_pkg::SLOT_NONE;
        end else begin
            // One lookup per frame; the extra stage covers the memory's read register
            lk_go <= sclk_rise && (bit_cnt == sbcreg_pkg::ADDR_BITS - 5'h01);
            lk_go_d <= lk_go;
            resp_go <= lk_go_d;
            if (lk_go) begin
                lk_ctrl <= ctrl_slot(rx[14:8]) != sbcreg_pkg::SLOT_NONE;
                lk_stat <= stat_slot(rx[14:8]) != sbcreg_pkg::SLOT_NONE;
                lk_slot <= (rx[14:8] <= sbcreg_pkg::CTRL_SPACE_END) ? ctrl_slot(rx[14:8])
                                                                    : stat_slot(rx[14:8]);
            end
        end
    end
    // Answer is the stored value, so a write in this frame shows next frame
    always_comb begin
        resp_mux = 8'h00;
        if (lk_ctrl) begin
            case (lk_slot)
                sbcreg_pkg::SLOT_MODE: resp_mux = {mode_field, 1'b0, reg_sw, mode_low};
                sbcreg_pkg::SLOT_CAN: resp_mux = {5'h00, can_reg};
                sbcreg_pkg::SLOT_HW0: begin
                    resp_mux = mem_rd;
                    resp_mux[sbcreg_pkg::FO_BIT] = fail_latched;
                end
                default: resp_mux = mem_rd;
            endcase
        end else if (lk_stat) begin
            case (lk_slot)
                sbcreg_pkg::STAT_SUP: resp_mux = sup_stat;
                sbcreg_pkg::STAT_DEV: resp_mux = dev_stat;
                sbcreg_pkg::STAT_WKLVL: resp_mux = {6'h00, wk_s};
                sbcreg_pkg::STAT_SWK: resp_mux = selective_wake_state;
                default: resp_mux = FAMILY_ID;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            resp_byte <= 8'h00;
            summary <= 8'h00;
        end else if (csn_fall) begin
            resp_byte <= 8'h00;
            summary <= {5'h00, |dev_stat, 1'b0, |sup_stat};
        end else if (resp_go) begin
            resp_byte <= resp_mux;
        end
    end
    assign resp_word = {resp_byte, summary};
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= !csn_s;
            if (csn_fall) begin
                spi_miso <= |sup_stat;
            end else if (sclk_fall) begin
                spi_miso <= resp_word[4'(fall_cnt + 4'h1)];
            end
        end
    end

    // ========================================================================
    // End of frame: decode of the write or clear
    logic apply, wr_ok, mode_wr, stat_clr;
    logic [4:0] c_slot, s_slot;
    logic [1:0] req_mode;
    assign apply = csn_rise && (bit_cnt == sbcreg_pkg::FRAME_BITS) && !frame_bad;
    assign c_slot = ctrl_slot(frame.addr);
    assign s_slot = stat_slot(frame.addr);
    assign req_mode = frame.data[sbcreg_pkg::MODE_MSB:sbcreg_pkg::MODE_LSB];
    always_comb begin
        wr_ok = 1'b0;
        if (apply && frame.access && c_slot != sbcreg_pkg::SLOT_NONE) begin
            case (mode_state)
                sbcreg_pkg::M_INIT, sbcreg_pkg::M_NORMAL: wr_ok = 1'b1;
                sbcreg_pkg::M_STOP: wr_ok = (c_slot == sbcreg_pkg::SLOT_WD)
                    || (c_slot == sbcreg_pkg::SLOT_MODE && req_mode == sbcreg_pkg::MODE_NORMAL);
                default: wr_ok = 1'b0;
            endcase
        end
    end
    assign mode_wr = wr_ok && (c_slot == sbcreg_pkg::SLOT_MODE);
    assign stat_clr = apply && frame.access && s_slot != sbcreg_pkg::SLOT_NONE;

    logic mem_wr_en;
    assign mem_wr_en = wr_ok && c_slot != sbcreg_pkg::SLOT_MODE && c_slot != sbcreg_pkg::SLOT_CAN;
    sbcreg_mem u_mem (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wr_en(mem_wr_en),
        .wr_idx(c_slot),
        .wr_data(frame.data & sbcreg_pkg::CTRL_MASK[c_slot]),
        .rd_idx(lk_slot),
        .rd_data(mem_rd)
    );

    // ========================================================================
    // Mode state machine
    always_comb begin
        next_mode = mode_state;
        case (mode_state)
            sbcreg_pkg::M_INIT, sbcreg_pkg::M_NORMAL: begin
                if (mode_wr) begin
                    case (req_mode)
                        sbcreg_pkg::MODE_SLEEP: next_mode = sbcreg_pkg::M_SLEEP;
                        sbcreg_pkg::MODE_STOP: next_mode = sbcreg_pkg::M_STOP;
                        sbcreg_pkg::MODE_RESET: next_mode = sbcreg_pkg::M_RESTART;
                        default: next_mode = sbcreg_pkg::M_NORMAL;
                    endcase
                end
            end
            sbcreg_pkg::M_STOP: if (mode_wr) begin
                next_mode = sbcreg_pkg::M_NORMAL;
            end
            sbcreg_pkg::M_SLEEP: if (wake_event) begin
                next_mode = sbcreg_pkg::M_RESTART;
            end
            sbcreg_pkg::M_RESTART: if (restart_done) begin
                next_mode = sbcreg_pkg::M_NORMAL;
            end
            default: next_mode = sbcreg_pkg::M_INIT;
        endcase
        if (restart_event) begin
            next_mode = sbcreg_pkg::M_RESTART;
        end
    end
    logic into_sleep, into_restart, low_power;
    assign into_sleep = next_mode == sbcreg_pkg::M_SLEEP && mode_state != sbcreg_pkg::M_SLEEP;
    assign into_restart = next_mode == sbcreg_pkg::M_RESTART
        && mode_state != sbcreg_pkg::M_RESTART;
    assign low_power = mode_state == sbcreg_pkg::M_STOP || mode_state == sbcreg_pkg::M_SLEEP;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mode_state <= sbcreg_pkg::M_INIT;
            mode_field <= sbcreg_pkg::MODE_NORMAL;
        end else begin
            mode_state <= next_mode;
            mode_field <= field_of(next_mode);
        end
    end
    assign sbc_mode = mode_state;

    // ========================================================================
    // Mode and supply control register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mode_low <= 3'h0;
            reg_sw <= 2'h0;
        end else begin
            if (mode_wr && mode_state != sbcreg_pkg::M_STOP) begin
                mode_low <= frame.data[sbcreg_pkg::MLOW_MSB:0];
            end
            if (into_restart) begin
                reg_sw <= 2'h0;
            end else if (low_power && regulator_fail) begin
                reg_sw <= 2'h0;
            end else if (mode_wr && mode_state == sbcreg_pkg::M_NORMAL) begin
                reg_sw <= frame.data[sbcreg_pkg::REGSW_MSB:sbcreg_pkg::REGSW_LSB];
            end
        end
    end
    assign secondary_regulator_switch = reg_sw;

    // ========================================================================
    // CAN transceiver control
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            can_reg <= sbcreg_pkg::CAN_OFF;
        end else if ((into_sleep || into_restart) && can_active(can_reg)) begin
            can_reg <= sbcreg_pkg::CAN_WAKE;
        end else if (wr_ok && c_slot == sbcreg_pkg::SLOT_CAN
                && next_mode != sbcreg_pkg::M_STOP) begin
            can_reg <= frame.data[sbcreg_pkg::CAN_MSB:0];
        end
    end
    assign can_mode = can_reg;

    // ========================================================================
    // Fail output, watchdog kick
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            fail_latched <= 1'b0;
            watchdog_kick <= 1'b0;
        end else begin
            watchdog_kick <= wr_ok && c_slot == sbcreg_pkg::SLOT_WD;
            if (fail_trigger) begin
                fail_latched <= 1'b1;
            end else if (wr_ok && c_slot == sbcreg_pkg::SLOT_HW0
                    && (mode_state == sbcreg_pkg::M_NORMAL
                    || frame.data[sbcreg_pkg::FO_BIT])) begin
                fail_latched <= frame.data[sbcreg_pkg::FO_BIT];
            end
        end
    end
    assign fail_output = fail_latched;

    // ========================================================================
    // Status flags: event set wins over clear; no clear on mode entry
    logic [7:0] sup_set;
    always_comb begin
        sup_set = supply_event;
        sup_set[sbcreg_pkg::REG_FAIL_BIT] = supply_event[sbcreg_pkg::REG_FAIL_BIT]
            | regulator_fail;
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sup_stat <= 8'h00;
            dev_stat <= 8'h00;
        end else begin
            // Clear only reaches clearable registers, live ones are not flops
            sup_stat <= ((stat_clr && s_slot == sbcreg_pkg::STAT_SUP) ? 8'h00 : sup_stat)
                | sup_set;
            dev_stat <= ((stat_clr && s_slot == sbcreg_pkg::STAT_DEV) ? 8'h00 : dev_stat)
                | device_event;
        end
    end

    // ========================================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_frame_end;
        csn_rise && bit_cnt == sbcreg_pkg::FRAME_BITS;
    endsequence
    sequence s_enter(sbcreg_pkg::sbcreg_mode_t m);
        next_mode == m && mode_state != m;
    endsequence
    a_write_at_end: assert property (mem_wr_en |-> s_frame_end)
        else $error("control write outside frame end");
    a_restart_frames: assert property (mode_state == sbcreg_pkg::M_RESTART |-> !wr_ok)
        else $error("write accepted in restart");
    a_stop_writes: assert property (mode_state == sbcreg_pkg::M_STOP && wr_ok
        |-> c_slot == sbcreg_pkg::SLOT_WD || c_slot == sbcreg_pkg::SLOT_MODE)
        else $error("illegal write in stop");
    a_mode_field: assert property (mode_field == field_of(mode_state))
        else $error("mode field disagrees with mode");
    a_fail_sticky: assert property (fail_latched && !(wr_ok && c_slot == sbcreg_pkg::SLOT_HW0)
        |=> fail_latched)
        else $error("fail output dropped");
    a_stop_can: assert property (s_enter(sbcreg_pkg::M_STOP) |=> $stable(can_reg))
        else $error("CAN field changed on stop entry");
    a_sleep_can: assert property (s_enter(sbcreg_pkg::M_SLEEP) |=> !can_active(can_reg))
        else $error("CAN active after sleep entry");
    a_reg_fail_off: assert property (low_power && regulator_fail
        |=> reg_sw == 2'h0 ##1 sup_stat[sbcreg_pkg::REG_FAIL_BIT])
        else $error("regulator not off after failure");
    a_restart_reg: assert property (s_enter(sbcreg_pkg::M_RESTART) |=> reg_sw == 2'h0)
        else $error("regulator bits kept in restart");
    a_reg_normal: assert property ($changed(reg_sw) && reg_sw != 2'h0
        |-> $past(mode_state) == sbcreg_pkg::M_NORMAL)
        else $error("regulator configured outside normal");
    a_set_wins: assert property (supply_event[0] |=> sup_stat[0])
        else $error("status event lost");
    a_write_late: assert property (resp_go ##1 (!csn_s)[*2] |-> $stable(resp_byte))
        else $error("answer byte changed mid frame");
endmodule
`default_nettype wire

// *** verif/sbcreg_spi_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbcreg_spi_master (
    // Serial pins
    output logic spi_sclk,
    output logic chip_select_low,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_sclk = 1'b0;
        chip_select_low = 1'b1;
        spi_mosi = 1'b0;
    end
    // Mode 0, LSB first; sclk stands still between frames
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        chip_select_low <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            spi_mosi <= tx[i];
            #80 spi_sclk <= 1'b1;
            rx[i] = spi_miso;
            #80 spi_sclk <= 1'b0;
        end
        #80 chip_select_low <= 1'b1;
        // Released line flips so a stale bit cannot pass
        spi_mosi <= ~spi_mosi;
        #200;
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic sclk, csn_low, mosi, miso, fail_trig = 1'b0, rst_ev = 1'b0, rst_done = 1'b0;
    logic [7:0] sup_ev = 8'h00;
    logic [1:0] wk_lvl = 2'b00;
    logic [7:0] q;
    sbcreg_pkg::sbcreg_mode_t sbc_mode;
    logic [2:0] can_mode;
    logic fail_output;
    logic reg_fail = 1'b0;
    logic wd_kick;
    logic [1:0] reg_sw;
    int kicks = 0;
    int failures = 0;
    int n_tests = 0;
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (wd_kick) kicks++;
    sbcreg_top dut (.sys_clk(sys_clk), .resetn(resetn), .spi_sclk(sclk),
        .chip_select_low(csn_low), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(),
        .wake_event(1'b0), .restart_event(rst_ev), .restart_done(rst_done),
        .fail_trigger(fail_trig), .regulator_fail(reg_fail), .supply_event(sup_ev),
        .device_event(8'h00), .selective_wake_state(8'h00), .wake_pin_level(wk_lvl),
        .sbc_mode(sbc_mode), .secondary_regulator_switch(reg_sw), .can_mode(can_mode),
        .fail_output(fail_output), .watchdog_kick(wd_kick));
    sbcreg_spi_master m (.spi_sclk(sclk), .chip_select_low(csn_low), .spi_mosi(mosi),
        .spi_miso(miso));
    // ========================================================================
    // Helpers
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic op(input logic [6:0] a, input logic w, input logic [7:0] d);
        logic [15:0] rx;
        @(posedge sys_clk);
        m.xfer({d, w, a}, rx);
        q = rx[15:8];
    endtask
    task automatic t_ctrl;
        op(7'h04, 1'b1, 8'hff);
        check("can old", 8'h00, q);
        check("can pins", 8'h07, {5'h00, can_mode});
        op(7'h04, 1'b0, 8'h00);
        check("can masked", 8'h07, q);
        op(7'h04, 1'b0, 8'h00);
        check("can kept", 8'h07, q);
        op(7'h05, 1'b1, 8'hff);
        op(7'h06, 1'b0, 8'h00);
        check("next reg", 8'h44, q);
        op(7'h7f, 1'b0, 8'h00);
        check("beyond", 8'h00, q);
    endtask
    task automatic t_stat;
        @(posedge sys_clk) sup_ev <= 8'h81;
        @(posedge sys_clk) sup_ev <= 8'h00;
        wk_lvl <= 2'b10;
        op(7'h41, 1'b1, 8'h00);
        check("sup clr", 8'h81, q);
        op(7'h41, 1'b0, 8'h00);
        check("sup gone", 8'h00, q);
        op(7'h48, 1'b1, 8'h00);
        op(7'h48, 1'b0, 8'h00);
        check("level", 8'h02, q);
        op(7'h7e, 1'b1, 8'h00);
        check("ident", 8'h5a, q);
    endtask
    task automatic t_mode;
        @(posedge sys_clk) fail_trig <= 1'b1;
        @(posedge sys_clk) fail_trig <= 1'b0;
        op(7'h01, 1'b1, 8'h80);
        check("stop", {3'h0, sbcreg_pkg::M_STOP}, {3'h0, sbc_mode});
        check("can stop", 8'h07, {5'h00, can_mode});
        check("fail stop", 8'h01, {7'h00, fail_output});
        op(7'h03, 1'b1, 8'h00);
        check("kick stop", 8'h01, 8'(kicks));
        op(7'h04, 1'b1, 8'h00);
        op(7'h04, 1'b0, 8'h00);
        check("stop write", 8'h07, q);
        @(posedge sys_clk) rst_ev <= 1'b1;
        @(posedge sys_clk) rst_ev <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("can rst", 8'h01, {5'h00, can_mode});
        check("fail rst", 8'h01, {7'h00, fail_output});
        op(7'h04, 1'b1, 8'h00);
        @(posedge sys_clk) rst_done <= 1'b1;
        @(posedge sys_clk) rst_done <= 1'b0;
        op(7'h04, 1'b0, 8'h00);
        check("rst ignored", 8'h01, q);
        op(7'h01, 1'b0, 8'h00);
        check("mode field", 8'h00, q);
    endtask
    task automatic t_sleep;
        op(7'h01, 1'b1, 8'h18);
        check("reg normal", 8'h03, {6'h00, reg_sw});
        op(7'h01, 1'b1, 8'hd8);
        check("reg restart", 8'h00, {6'h00, reg_sw});
        check("mode restart", {3'h0, sbcreg_pkg::M_RESTART}, {3'h0, sbc_mode});
        @(posedge sys_clk) rst_done <= 1'b1;
        @(posedge sys_clk) rst_done <= 1'b0;
        @(posedge sys_clk) sup_ev <= 8'h01;
        @(posedge sys_clk) sup_ev <= 8'h00;
        op(7'h04, 1'b1, 8'h03);
        check("can flagged", 8'h03, {5'h00, can_mode});
        op(7'h01, 1'b1, 8'h58);
        check("can sleep", 8'h01, {5'h00, can_mode});
        check("reg sleep", 8'h03, {6'h00, reg_sw});
        @(posedge sys_clk) reg_fail <= 1'b1;
        @(posedge sys_clk) reg_fail <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("reg fail", 8'h00, {6'h00, reg_sw});
        check("no wake", {3'h0, sbcreg_pkg::M_SLEEP}, {3'h0, sbc_mode});
    endtask
    task automatic results;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        t_ctrl();
        t_stat();
        t_mode();
        t_sleep();
        results();
    end
    initial begin
        #300000;
        failures++;
        results();
    end
endmodule
`default_nettype wire
